/* dv/lwi_host_model.sv */
`timescale 1ns/100ps
module lwi_host_model
   import lwi_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic irq_line_n, // Interrupt wire
   input wire lwi_irq_t flags, // Status read back
   input wire lwi_irq_t svc_mask, // Flags it services
   input wire logic [7:0] svc_delay, // Reaction time
   output lwi_irq_t irq_clear // Write-1 strobes
);
   logic [7:0] wait_reg;
   // Polls status some cycles after the line falls; unserviced bits get a 0 written
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_reg <= 8'h0;
         irq_clear <= '0;
      end
      else if (irq_clear != '0 || irq_line_n)
      begin
         wait_reg <= 8'h0;
         irq_clear <= '0;
      end
      else if (wait_reg == svc_delay)
      begin
         wait_reg <= 8'h0;
         irq_clear <= lwi_irq_t'(flags & svc_mask);
      end
      else
         wait_reg <= wait_reg + 8'h1;
   end
endmodule : lwi_host_model

/* dv/lwi_wake_irq_asserts.sv */
`timescale 1ns/100ps
module lwi_wake_irq_asserts
   import lwi_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic local_wake_pin_a, // Pin A
   input wire logic [1:0] wake_edge_cfg_a, // Edge A
   input wire logic wake_sync_enable_a, // Sync A
   input wire logic [1:0] operating_mode_field, // Mode
   input wire logic transceiver_standby_ctl, // Standby
   input wire logic transceiver_lowpower, // Low power
   input wire logic watchdog_timeout_mode, // Timeout
   input wire logic watchdog_overflow, // Overflow
   input wire logic watchdog_disable_pin, // WD off
   input wire lwi_irq_t irq_clear, // Clears
   input wire lwi_irq_t irq_flags, // Flags
   input wire logic wake_bias_output, // Bias
   input wire logic bus_wake_pending, // Pending
   input wire logic cyclic_irq_enabled, // Armed
   input wire logic sleep_exit_req, // Exit
   input wire logic irq_out_n_out, // Pin value
   input wire logic irq_out_n_oe_n // Pin enable
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // The previous sample only counts once it was taken out of reset
   sequence s_rise_a;
      $past(rst_n) && !$past(wake_sync_enable_a) && !wake_sync_enable_a
         && !$past(local_wake_pin_a) && local_wake_pin_a;
   endsequence
   sequence s_armed_ovf;
      cyclic_irq_enabled && watchdog_timeout_mode && watchdog_overflow;
   endsequence
   a_irq_pin_drive: assert property (irq_out_n_oe_n == !(|irq_flags) && !irq_out_n_out)
      else $error("interrupt pin does not follow flags");
   a_wake_rise_a: assert property (wake_edge_cfg_a[0] ##0 s_rise_a |=> irq_flags.wake_a)
      else $error("rising wake edge missed");
   a_wake_off_a: assert property (wake_edge_cfg_a == 2'h0 && !irq_flags.wake_a |=> !irq_flags.wake_a)
      else $error("disabled wake pin raised a flag");
   a_flag_sticky: assert property (irq_flags.wake_a && !irq_clear.wake_a |=> irq_flags.wake_a)
      else $error("wake flag dropped without clear");
   a_clear_cyclic: assert property (irq_clear.cyclic && !watchdog_overflow |=> !irq_flags.cyclic)
      else $error("cyclic flag not cleared");
   a_sleep_exit: assert property (operating_mode_field == 2'h1 && wake_edge_cfg_a[0] ##0 s_rise_a
      |=> sleep_exit_req) else $error("no sleep exit on wake edge");
   // The sample is taken at the edge after the bias rises, the flag shows one edge later
   a_sync_bias: assert property ($rose(irq_flags.wake_a) && $past(wake_sync_enable_a)
      |-> $past(wake_bias_output) && !$past(wake_bias_output, 2))
      else $error("synced wake flag off bias edge");
   a_cyclic_arm: assert property ($past(rst_n) && $rose(watchdog_timeout_mode)
      && operating_mode_field != 2'h1 && !watchdog_disable_pin |=> cyclic_irq_enabled)
      else $error("cyclic interrupt not armed");
   a_cyclic_raise: assert property (s_armed_ovf |=> irq_flags.cyclic)
      else $error("overflow did not raise cyclic flag");
   a_pend_clear: assert property (operating_mode_field[1] && !transceiver_standby_ctl
      && !transceiver_lowpower |=> !bus_wake_pending) else $error("pending wake kept in normal");
endmodule : lwi_wake_irq_asserts

bind lwi_wake_irq lwi_wake_irq_asserts i_lwi_wake_irq_asserts (.*);

/* dv/lwi_wake_irq_bench.sv */
`timescale 1ns/100ps
module lwi_wake_irq_bench;
   import lwi_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin_a = 1'b0, pin_b = 1'b0, sync_a = 1'b0, sync_b = 1'b0, bias_sel = 1'b0;
   logic [1:0] cfg_a = 2'h0, cfg_b = 2'h0, mode = 2'h0;
   logic stb = 1'b0, bus_ev = 1'b0, wd_tmo = 1'b0, wd_ovf = 1'b0, wd_off = 1'b0;
   lwi_irq_t svc_mask = '0, clr, flags;
   logic lvl_a, lvl_b, bias, pend, cyc_en, exit_req, lowpwr, det_en, od_val, od_oe_n, irq_n;
   logic line_low;
   int num_errors = 0, n_tests = 0;

   initial
   begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Pull-up on the open-drain line
   assign irq_n = od_oe_n ? 1'b1 : od_val;

   lwi_wake_irq #(.BIAS_SHORT_CYC(40), .BIAS_LONG_CYC(160), .BIAS_ON_CYC(4)) i_lwi_wake_irq (
      .ref_clk(ref_clk), .rst_n(rst_n), .local_wake_pin_a(pin_a), .local_wake_pin_b(pin_b),
      .wake_edge_cfg_a(cfg_a), .wake_edge_cfg_b(cfg_b), .wake_sync_enable_a(sync_a),
      .wake_sync_enable_b(sync_b), .bias_period_select(bias_sel), .operating_mode_field(mode),
      .transceiver_standby_ctl(stb), .bus_wake_event(bus_ev), .watchdog_timeout_mode(wd_tmo),
      .watchdog_overflow(wd_ovf), .watchdog_disable_pin(wd_off), .irq_clear(clr),
      .irq_out_n_in(irq_n), .irq_flags(flags), .wake_level_flag_a(lvl_a),
      .wake_level_flag_b(lvl_b), .wake_bias_output(bias), .bus_wake_pending(pend),
      .cyclic_irq_enabled(cyc_en), .sleep_exit_req(exit_req), .transceiver_lowpower(lowpwr),
      .bus_wake_detect_en(det_en), .irq_out_n_out(od_val), .irq_out_n_oe_n(od_oe_n),
      .irq_line_low(line_low));
   lwi_host_model i_lwi_host_model (.ref_clk(ref_clk), .rst_n(rst_n), .irq_line_n(irq_n),
      .flags(flags), .svc_mask(svc_mask), .svc_delay(8'h2), .irq_clear(clr));

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic chk_int(input string what, input int exp, input int got);
      n_tests++;
      if (got != exp)
      begin
         num_errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_int
   task automatic host_clear(input lwi_irq_t m);
      svc_mask <= m;
      tick(8);
      svc_mask <= '0;
      tick(1);
   endtask : host_clear
   // Called at a rise, n comes back as one full bias period
   task automatic wait_bias(output int n);
      n = 0;
      while (bias !== 1'b0 && n < 1000)
      begin
         tick(1);
         n++;
      end
      while (bias !== 1'b1 && n < 1000)
      begin
         tick(1);
         n++;
      end
   endtask : wait_bias
   task automatic t_edges();
      for (int c = 0; c < 4; c++)
      begin
         cfg_a <= c[1:0];
         tick(3);
         pin_a <= 1'b1;
         tick(3);
         chk_bit("rise flag", c[0], flags.wake_a);
         chk_bit("irq wire", ~c[0], irq_n);
         chk_bit("line low", c[0], line_low);
         chk_bit("level a", c != 0, lvl_a);
         host_clear(lwi_irq_t'(4'h1));
         chk_bit("flag clear", 1'b0, flags.wake_a);
         chk_bit("wire release", 1'b1, irq_n);
         pin_a <= 1'b0;
         tick(3);
         chk_bit("fall flag", c[1], flags.wake_a);
         host_clear(lwi_irq_t'(4'h1));
      end
      cfg_a <= 2'h0;
   endtask : t_edges
   task automatic t_sleep();
      mode <= 2'h1;
      cfg_b <= 2'h2;
      cfg_a <= 2'h1;
      pin_b <= 1'b1;
      tick(3);
      chk_bit("level b", 1'b1, lvl_b);
      pin_b <= 1'b0;
      tick(2);
      chk_bit("exit pulse", 1'b1, exit_req);
      tick(1);
      chk_bit("exit end", 1'b0, exit_req);
      pin_a <= 1'b1;
      tick(2);
      chk_bit("exit pulse a", 1'b1, exit_req);
      mode <= 2'h0;
      cfg_b <= 2'h0;
      cfg_a <= 2'h0;
      pin_a <= 1'b0;
      host_clear(lwi_irq_t'(4'h3));
   endtask : t_sleep
   task automatic t_sync();
      int n;
      cfg_a <= 2'h1;
      cfg_b <= 2'h1;
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      wait_bias(n);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      tick(6);
      chk_bit("sync hold", 1'b0, flags.wake_a);
      chk_bit("sync hold b", 1'b0, flags.wake_b);
      wait_bias(n);
      // The sample is taken at this edge; the flag shows one edge later
      tick(1);
      chk_bit("sync take", 1'b1, flags.wake_a);
      chk_bit("sync take b", 1'b1, flags.wake_b);
      wait_bias(n);
      wait_bias(n);
      chk_int("short period", 40, n);
      bias_sel <= 1'b1;
      wait_bias(n);
      wait_bias(n);
      chk_int("long period", 160, n);
      bias_sel <= 1'b0;
      cfg_a <= 2'h0;
      cfg_b <= 2'h0;
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      host_clear(lwi_irq_t'(4'h3));
   endtask : t_sync
   task automatic t_cyclic();
      wd_tmo <= 1'b1;
      tick(2);
      chk_bit("cyclic armed", 1'b1, cyc_en);
      wd_ovf <= 1'b1;
      tick(1);
      wd_ovf <= 1'b0;
      tick(2);
      chk_bit("cyclic flag", 1'b1, flags.cyclic);
      host_clear(lwi_irq_t'(4'h7));
      chk_bit("write zero", 1'b1, flags.cyclic);
      host_clear(lwi_irq_t'(4'h8));
      chk_bit("write one", 1'b0, flags.cyclic);
      wd_tmo <= 1'b0;
      wd_off <= 1'b1;
      tick(2);
      wd_tmo <= 1'b1;
      tick(2);
      chk_bit("cyclic off", 1'b0, cyc_en);
      wd_tmo <= 1'b0;
      wd_off <= 1'b0;
   endtask : t_cyclic
   task automatic t_bus();
      for (int m = 2; m < 4; m++)
      begin
         mode <= 2'h0;
         stb <= 1'b1;
         tick(2);
         chk_bit("low power", 1'b1, lowpwr & det_en);
         bus_ev <= 1'b1;
         tick(1);
         bus_ev <= 1'b0;
         tick(2);
         chk_bit("bus flag", 1'b1, flags.bus_wake);
         host_clear(lwi_irq_t'(4'h4));
         chk_bit("bus flag clr", 1'b0, flags.bus_wake);
         chk_bit("pend kept", 1'b1, pend);
         mode <= m[1:0];
         tick(3);
         chk_bit("pend stb on", 1'b1, pend);
         stb <= 1'b0;
         tick(3);
         chk_bit("pend normal", 1'b0, pend);
      end
   endtask : t_bus
   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      tick(4);
      rst_n <= 1'b1;
      tick(2);
      t_edges();
      t_sleep();
      t_sync();
      t_cyclic();
      t_bus();
      wrap_up();
   end
   initial
   begin
      tick(20000);
      num_errors++;
      wrap_up();
   end
endmodule : lwi_wake_irq_bench

/* logic/lwi_bias_gen.sv */
`timescale 1ns/100ps
`include "lwi_regs.svh"

module lwi_bias_gen
   import lwi_pkg::*;
#(
   parameter int unsigned SHORT_CYC = `LWI_BIAS_SHORT_CYC,
   parameter int unsigned LONG_CYC = `LWI_BIAS_LONG_CYC,
   parameter int unsigned ON_CYC = `LWI_BIAS_ON_CYC
)
(
   input wire logic ref_clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic bias_period_select, // 0: short period, 1: long period
   output logic wake_bias_output, // Bias drive to the wake pins
   output logic bias_rise // One-cycle pulse with each bias rising edge except the first one after reset
);

   localparam int CW = $clog2(LONG_CYC + 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [CW-1:0] last_cnt;

   // Period change takes effect at the next wrap only if the count is below it
   assign last_cnt = bias_period_select ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
   assign cnt_next = (cnt_reg >= last_cnt) ? '0 : cnt_reg + CW'(1);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         wake_bias_output <= 1'b0;
         bias_rise <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         wake_bias_output <= (cnt_next < CW'(ON_CYC));
         bias_rise <= (cnt_next == '0);
      end
   end

endmodule : lwi_bias_gen

/* logic/lwi_wake_irq.sv */
`timescale 1ns/100ps
`include "lwi_regs.svh"

// What this block does
// - Each wake pin has its own two-bit field choosing falling, rising or both edges.
// - The same field at its off code disables wake detection for that pin.
// - Qualifying wake edge in Standby or Normal raises a wake interrupt flag.
// - Qualifying wake edge in Sleep requests a move to Standby.
// - Each wake pin level is shown in its own level status bit.
// - Level status bits update only while some edge field is not off.
// - Sync enable 1 samples the pin with the bias signal; 0 samples continuously.
// - Synchronised sampling happens at the clock edge after each rising edge of the bias output except the first one after reset.
// - One bias control bit selects a 16 ms or 64 ms sampling period.
// - Open-drain active-low interrupt pin is pulled low while any flag is pending.
// - Clearing the bus wake flag in Standby leaves the pending bus wake request.
// - Pending bus wake request clears while in Normal with transceiver standby 0.
// - Cyclic interrupt enables when watchdog enters Timeout in Standby/Normal, disable pin low.
// - Each watchdog overflow in Timeout mode raises the cyclic interrupt flag while the cyclic interrupt is enabled.
// - Mode field 10 and 11 mean Normal, 00 Standby, 01 Sleep.
// - Transceiver standby bit 1 selects low power with bus wake detection on.

module lwi_wake_irq
   import lwi_pkg::*;
#(
   parameter int unsigned BIAS_SHORT_CYC = `LWI_BIAS_SHORT_CYC,
   parameter int unsigned BIAS_LONG_CYC = `LWI_BIAS_LONG_CYC,
   parameter int unsigned BIAS_ON_CYC = `LWI_BIAS_ON_CYC,
   parameter bit HAS_WATCHDOG = 1'b1
)
(
   input wire logic ref_clk, // System clock, 25 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic local_wake_pin_a, // Wake pin A level
   input wire logic local_wake_pin_b, // Wake pin B level
   input wire logic [1:0] wake_edge_cfg_a, // Edge select for pin A
   input wire logic [1:0] wake_edge_cfg_b, // Edge select for pin B
   input wire logic wake_sync_enable_a, // Sample pin A with the bias
   input wire logic wake_sync_enable_b, // Sample pin B with the bias
   input wire logic bias_period_select, // 0: 16 ms, 1: 64 ms
   input wire logic [1:0] operating_mode_field, // Device mode
   input wire logic transceiver_standby_ctl, // 1: transceiver low power
   input wire logic bus_wake_event, // Pulse from the bus wake filter
   input wire logic watchdog_timeout_mode, // Watchdog is in Timeout mode
   input wire logic watchdog_overflow, // Pulse on watchdog overflow
   input wire logic watchdog_disable_pin, // High disables the watchdog
   input wire lwi_irq_t irq_clear, // Write-1-to-clear strobes
   input wire logic irq_out_n_in, // Interrupt pin level as seen on the wire
   output lwi_irq_t irq_flags, // Pending interrupt flags
   output logic wake_level_flag_a, // Level status of pin A
   output logic wake_level_flag_b, // Level status of pin B
   output logic wake_bias_output, // Bias drive to the wake pins
   output logic bus_wake_pending, // Pending bus wake request
   output logic cyclic_irq_enabled, // Cyclic interrupt armed
   output logic sleep_exit_req, // Pulse: leave Sleep for Standby
   output logic transceiver_lowpower, // Transceiver in low power
   output logic bus_wake_detect_en, // Bus wake detection active
   output logic irq_out_n_out, // Interrupt pin drive value, always low
   output logic irq_out_n_oe_n, // Interrupt pin enable, low drives
   output logic irq_line_low // Registered inverted pin level (1 while the wire is low), for loop-back checks
);

   lwi_mode_t mode;
   logic mode_active;
   logic bias_rise;
   logic [1:0] pin_vec;
   logic [1:0] sync_vec;
   logic [1:0] cfg_vec [2];
   logic [1:0] level_vec;
   logic [1:0] edge_hit;
   logic any_cfg_on;
   logic wake_any;
   logic wd_tmo_prev_reg;
   logic tmo_entry;
   lwi_irq_t flags_reg;
   lwi_irq_t flags_next;
   lwi_irq_t set_vec;
   logic [1:0] level_reg;
   logic pending_reg;
   logic cyc_en_reg;
   logic sleep_exit_reg;
   logic lowpower_reg;
   logic oe_n_reg;
   logic line_low_reg;

   assign mode = lwi_decode_mode(operating_mode_field);
   assign mode_active = (mode == LWI_STANDBY) || (mode == LWI_NORMAL);

   assign pin_vec = {local_wake_pin_b, local_wake_pin_a};
   assign sync_vec = {wake_sync_enable_b, wake_sync_enable_a};
   assign cfg_vec[0] = wake_edge_cfg_a;
   assign cfg_vec[1] = wake_edge_cfg_b;
   assign any_cfg_on = (wake_edge_cfg_a != `LWI_EDGE_OFF) || (wake_edge_cfg_b != `LWI_EDGE_OFF);

   // Bias runs all the time so the period is stable when sync sampling is switched on
   lwi_bias_gen #(
      .SHORT_CYC(BIAS_SHORT_CYC),
      .LONG_CYC(BIAS_LONG_CYC),
      .ON_CYC(BIAS_ON_CYC)
   ) u_bias (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .bias_period_select(bias_period_select),
      .wake_bias_output(wake_bias_output),
      .bias_rise(bias_rise)
   );

   // Per-pin sampling and edge qualification
   for (genvar i = 0; i < 2; i++)
   begin : g_pin
      logic smp_reg;
      logic smp_valid_reg;
      logic take;
      logic rise;
      logic fall;

      // Sync sampling looks at the pin only once per bias period
      assign take = sync_vec[i] ? bias_rise : 1'b1;
      assign rise = take && smp_valid_reg && !smp_reg && pin_vec[i];
      assign fall = take && smp_valid_reg && smp_reg && !pin_vec[i];

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            smp_reg <= 1'b0;
            smp_valid_reg <= 1'b0;
         end
         else if (take)
         begin
            smp_reg <= pin_vec[i];
            smp_valid_reg <= 1'b1;
         end
      end

      always_comb
      begin
         case (cfg_vec[i])
            `LWI_EDGE_RISE: edge_hit[i] = rise;
            `LWI_EDGE_FALL: edge_hit[i] = fall;
            `LWI_EDGE_BOTH: edge_hit[i] = rise || fall;
            default: edge_hit[i] = 1'b0;
         endcase
      end

      assign level_vec[i] = smp_reg;
   end

   assign wake_any = |edge_hit;

   // Level status follows the sampled pin only while some wake input is enabled
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_reg <= {2{`LWI_LEVEL_RST}};
      end
      else if (any_cfg_on)
      begin
         level_reg <= level_vec;
      end
   end

   assign wake_level_flag_a = level_reg[0];
   assign wake_level_flag_b = level_reg[1];

   // Sleep exit request; the mode controller moves the device to Standby
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sleep_exit_reg <= 1'b0;
      end
      else
      begin
         sleep_exit_reg <= wake_any && (mode == LWI_SLEEP);
      end
   end

   assign sleep_exit_req = sleep_exit_reg;

   // Transceiver power state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lowpower_reg <= 1'b0;
      end
      else
      begin
         lowpower_reg <= transceiver_standby_ctl;
      end
   end

   assign transceiver_lowpower = lowpower_reg;
   assign bus_wake_detect_en = lowpower_reg;

   // Pending bus wake request, independent of its flag
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending_reg <= 1'b0;
      end
      else if (bus_wake_event && lowpower_reg)
      begin
         pending_reg <= 1'b1;
      end
      else if ((mode == LWI_NORMAL) && !transceiver_standby_ctl)
      begin
         pending_reg <= 1'b0;
      end
   end

   assign bus_wake_pending = pending_reg;

   // Cyclic interrupt arming on entry to watchdog Timeout mode
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_tmo_prev_reg <= 1'b0;
      end
      else
      begin
         wd_tmo_prev_reg <= watchdog_timeout_mode;
      end
   end

   assign tmo_entry = watchdog_timeout_mode && !wd_tmo_prev_reg;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cyc_en_reg <= 1'b0;
      end
      else if (!HAS_WATCHDOG || watchdog_disable_pin || !watchdog_timeout_mode)
      begin
         cyc_en_reg <= 1'b0;
      end
      else if (tmo_entry && mode_active)
      begin
         cyc_en_reg <= 1'b1;
      end
   end

   assign cyclic_irq_enabled = cyc_en_reg;

   // Flag sources
   always_comb
   begin
      set_vec = '0;
      set_vec.wake_a = edge_hit[0];
      set_vec.wake_b = edge_hit[1];
      set_vec.bus_wake = bus_wake_event && lowpower_reg;
      set_vec.cyclic = cyc_en_reg && watchdog_timeout_mode && watchdog_overflow;
   end

   // Clearing a flag never touches the pending request above
   // A source firing in the same cycle as its clear keeps the flag set
   assign flags_next = (flags_reg & ~irq_clear) | set_vec;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_reg <= `LWI_FLAGS_RST;
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   assign irq_flags = flags_reg;

   // Interrupt pin drive; registered so the enable cannot glitch
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         oe_n_reg <= 1'b1;
         line_low_reg <= 1'b0;
      end
      else
      begin
         oe_n_reg <= ~(|flags_next);
         line_low_reg <= !irq_out_n_in;
      end
   end

   assign irq_out_n_out = 1'b0;
   assign irq_out_n_oe_n = oe_n_reg;
   assign irq_line_low = line_low_reg;

endmodule : lwi_wake_irq

/* shared/lwi_pkg.sv */
package lwi_pkg;

   // One bit per interrupt source; used for flags and write-1 clear strobes
   typedef struct packed {
      logic cyclic;
      logic bus_wake;
      logic wake_b;
      logic wake_a;
   } lwi_irq_t;

   typedef enum logic [1:0] {
      LWI_STANDBY,
      LWI_SLEEP,
      LWI_NORMAL
   } lwi_mode_t;

   function automatic lwi_mode_t lwi_decode_mode(input logic [1:0] field);
      lwi_mode_t m;
      m = LWI_STANDBY;
      case (field)
         2'h0: m = LWI_STANDBY;
         2'h1: m = LWI_SLEEP;
         default: m = LWI_NORMAL;
      endcase
      return m;
   endfunction : lwi_decode_mode

endpackage : lwi_pkg

/* shared/lwi_regs.svh */
`ifndef LWI_REGS_SVH
`define LWI_REGS_SVH

// Reference clock rate
`define LWI_CLK_HZ 25000000

// Wake edge configuration codes
`define LWI_EDGE_OFF 2'h0
`define LWI_EDGE_RISE 2'h1
`define LWI_EDGE_FALL 2'h2
`define LWI_EDGE_BOTH 2'h3

// Operating mode field codes
`define LWI_MODE_STANDBY 2'h0
`define LWI_MODE_SLEEP 2'h1
`define LWI_MODE_NORMAL_A 2'h2
`define LWI_MODE_NORMAL_B 2'h3

// Bias sampling periods and bias on-time
`define LWI_BIAS_SHORT_MS 16
`define LWI_BIAS_LONG_MS 64
`define LWI_BIAS_ON_US 1000
`define LWI_BIAS_SHORT_CYC (`LWI_BIAS_SHORT_MS * (`LWI_CLK_HZ / 1000))
`define LWI_BIAS_LONG_CYC (`LWI_BIAS_LONG_MS * (`LWI_CLK_HZ / 1000))
`define LWI_BIAS_ON_CYC (`LWI_BIAS_ON_US * (`LWI_CLK_HZ / 1000000))

// Reset values
`define LWI_FLAGS_RST 4'h0
`define LWI_LEVEL_RST 1'h0

`endif
